// ==== pkg/psci_pkg.sv ====
// Shared constants for the presence-sensing cycle initiation block
package psci_pkg;
  // Clock rate and time bases
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYCLES_PER_MS_DEF = CLK_HZ / MS_PER_S;
  // Minimum low time and restart pulse choices, in ms
  localparam logic [8:0] MIN_SHORT_MS = 9'd100;
  localparam logic [8:0] MIN_LONG_MS = 9'd350;
  // Restart pulses longer than this are ignored, in ms
  localparam logic [14:0] RESTART_MAX_MS = 15'd30000;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TMO_OFS = 8'h04;
  localparam logic [7:0] MUTE_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  // Control field positions
  localparam int unsigned CNT_LSB = 0;
  localparam int unsigned MODE_BIT = 3;
  localparam int unsigned ILK_LSB = 4;
  localparam int unsigned REL2_LSB = 6;
  localparam int unsigned FIRST_BIT = 8;
  localparam int unsigned RMIN_BIT = 9;
  localparam int unsigned PMIN_BIT = 10;
  // Reset values
  localparam logic [10:0] CTRL_RST = 11'h000;
  localparam logic [8:0] TMO_RST = 9'd30;
  localparam logic [12:0] MUTE_RST = 13'h0000;
  // Field encodings
  localparam logic [1:0] ILK_ALL = 2'h0;
  localparam logic [1:0] ILK_DOWN_TOP = 2'h1;
  localparam logic [1:0] ILK_NONE = 2'h2;
  localparam logic [1:0] REL2_OFF = 2'h0;
  localparam logic [1:0] REL2_FIRST = 2'h1;
  localparam logic [1:0] REL2_EVERY = 2'h2;
  // Input vector bit positions
  localparam int unsigned IN_PRESENCE_SENSING_INITIATION = 0;
  localparam int unsigned IN_STAT = 1;
  localparam int unsigned IN_REL2 = 2;
  localparam int unsigned IN_TDC = 3;
  localparam int unsigned IN_UP = 4;
  localparam int unsigned IN_RST = 5;
  localparam int unsigned IN_DRV = 6;
  localparam int unsigned IN_W = 7;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_FULL = 4'h1,
    ST_CYCLE = 4'h2,
    ST_RESUME = 4'h4,
    ST_RUN = 4'h8
  } psci_state_type;
endpackage : psci_pkg

// ==== rtl/psci_core.sv ====
// Cycle initiation sequencer with Wishbone register access
//
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/1ns
module psci_core #(
  parameter int unsigned CYCLES_PER_MS = psci_pkg::CYCLES_PER_MS_DEF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Press and sensor inputs
  input wire logic presence_sensing_initiation,
  input wire logic release_static,
  input wire logic release_start,
  input wire logic top_dead_center,
  input wire logic upstroke,
  input wire logic restart,
  input wire logic drive_released,
  // Results
  output logic release_out,
  output logic timeout_flag,
  output logic unexpected_flag,
  output logic restart_required
);

  // Byte-lane merge for register writes
  function automatic logic [31:0] psci_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : psci_merge

  // Seconds to milliseconds, used for timeout and muting limits
  function automatic logic [22:0] psci_s_to_ms(input logic [12:0] s);
    return 23'(s) * 23'(psci_pkg::MS_PER_S);
  endfunction : psci_s_to_ms

  // Saturating millisecond counter step
  function automatic logic [22:0] psci_sat_inc(input logic [22:0] v);
    return (&v) ? v : v + 23'd1;
  endfunction : psci_sat_inc

  // Configuration registers
  logic [10:0] ctrl_r;
  logic [8:0] tmo_s_r;
  logic [12:0] mute_s_r;
  // Bus handshake and read data
  logic ack_r;
  logic [31:0] rdat_r;
  // Input synchronisers: three stages, filtered level, previous sample
  logic [psci_pkg::IN_W-1:0] s1_r, s2_r, s3_r, filt_r, prev_r;
  // Millisecond prescaler
  logic [31:0] pre_r;
  // Timers in ms
  logic [22:0] low_ms_r, rst_ms_r, seq_ms_r, mute_ms_r;
  // Sequence state
  psci_pkg::psci_state_type state_r, state_nxt;
  logic [3:0] count_r;
  logic restart_done_r, tdc_arm_r, up_arm_r, fall_ok_r;
  logic release_r, timeout_r, unexp_r;

  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire bus_wr = bus_req & wb_we_i & ack_r;
  wire sel_ctrl = (wb_adr_i == psci_pkg::CTRL_OFS);
  wire sel_tmo = (wb_adr_i == psci_pkg::TMO_OFS);
  wire sel_mute = (wb_adr_i == psci_pkg::MUTE_OFS);
  wire sel_stat = (wb_adr_i == psci_pkg::STAT_OFS);

  // Configuration fields
  wire [2:0] cnt_m1 = ctrl_r[psci_pkg::CNT_LSB +: 3];
  wire mode_alt = ctrl_r[psci_pkg::MODE_BIT];
  wire [1:0] ilk = ctrl_r[psci_pkg::ILK_LSB +: 2];
  wire [1:0] rel2_cond = ctrl_r[psci_pkg::REL2_LSB +: 2];
  wire first_up = ctrl_r[psci_pkg::FIRST_BIT];
  wire [8:0] rst_min = ctrl_r[psci_pkg::RMIN_BIT] ? psci_pkg::MIN_LONG_MS
                                                   : psci_pkg::MIN_SHORT_MS;
  wire [8:0] low_min = ctrl_r[psci_pkg::PMIN_BIT] ? psci_pkg::MIN_LONG_MS
                                                   : psci_pkg::MIN_SHORT_MS;
  wire [3:0] target = {1'b0, cnt_m1} + 4'h1;

  // Filtered levels and edges against the previous sample
  wire presence_sensing_initiation_f = filt_r[psci_pkg::IN_PRESENCE_SENSING_INITIATION];
  wire stat_f = filt_r[psci_pkg::IN_STAT];
  wire rel2_f = filt_r[psci_pkg::IN_REL2];
  wire tdc_f = filt_r[psci_pkg::IN_TDC];
  wire up_f = filt_r[psci_pkg::IN_UP];
  wire [psci_pkg::IN_W-1:0] rise = filt_r & ~prev_r;
  wire [psci_pkg::IN_W-1:0] fall = ~filt_r & prev_r;
  wire presence_sensing_initiation_fall = fall[psci_pkg::IN_PRESENCE_SENSING_INITIATION];
  wire presence_sensing_initiation_rise = rise[psci_pkg::IN_PRESENCE_SENSING_INITIATION];
  wire tdc_rise = rise[psci_pkg::IN_TDC];
  wire up_rise = rise[psci_pkg::IN_UP];
  wire rst_fall = fall[psci_pkg::IN_RST];
  wire drv_rise = rise[psci_pkg::IN_DRV];
  wire ms_tick = (pre_r == CYCLES_PER_MS - 1);

  // Muting: only with a nonzero limit, upstroke high, top low, not expired
  wire mute_on = (mute_s_r != 13'h0000);
  wire mute_exp = (mute_ms_r >= psci_s_to_ms(mute_s_r));
  wire muted = mute_on & up_f & ~tdc_f & ~mute_exp;

  // Valid interruption: long enough, start and end after arming or within the full sequence
  wire in_full = (state_r == psci_pkg::ST_FULL);
  wire end_ok = tdc_arm_r | in_full;
  wire long_low = (low_ms_r >= 23'(low_min));
  wire cnt_gate = ~mode_alt | restart_done_r | ~in_full;
  wire count_inc = presence_sensing_initiation_rise & fall_ok_r & end_ok & long_low & cnt_gate &
                   (count_r < target);
  wire count_done = (count_r == target);

  // Valid restart pulse: between minimum and the long cutoff
  wire restart_ok = rst_fall & (rst_ms_r >= 23'(rst_min)) &
                    (rst_ms_r <= 23'(psci_pkg::RESTART_MAX_MS));

  // Sequence timeout, off when the limit is zero
  wire seq_timed = in_full | (state_r == psci_pkg::ST_CYCLE);
  wire tmo_hit = seq_timed & (tmo_s_r != 9'h000) &
                 (seq_ms_r >= psci_s_to_ms(13'(tmo_s_r)));

  // Second release requirement
  wire need_rel2 = (rel2_cond == psci_pkg::REL2_EVERY) |
                   ((rel2_cond == psci_pkg::REL2_FIRST) & in_full);
  wire rel2_ok = ~need_rel2 | rel2_f;
  wire full_done = mode_alt ? (restart_done_r & count_done)
                            : (count_done & restart_ok);
  wire unexp_stop = presence_sensing_initiation_fall & ~muted;
  wire soft_resume = (ilk == psci_pkg::ILK_NONE) |
                     ((ilk == psci_pkg::ILK_DOWN_TOP) & up_f);
  wire go_run = (state_nxt == psci_pkg::ST_RUN) & (state_r != psci_pkg::ST_RUN);

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      psci_pkg::ST_FULL: begin
        if (stat_f & rel2_ok & full_done) begin
          state_nxt = psci_pkg::ST_RUN;
        end
      end
      psci_pkg::ST_CYCLE: begin
        if (tmo_hit | drv_rise) begin
          state_nxt = psci_pkg::ST_FULL;
        end else if (stat_f & rel2_ok & count_done) begin
          state_nxt = psci_pkg::ST_RUN;
        end
      end
      psci_pkg::ST_RESUME: begin
        if (drv_rise) begin
          state_nxt = psci_pkg::ST_FULL;
        end else if (stat_f & presence_sensing_initiation_f) begin
          state_nxt = psci_pkg::ST_RUN;
        end
      end
      psci_pkg::ST_RUN: begin
        if (tdc_rise) begin
          state_nxt = psci_pkg::ST_CYCLE;
        end else if (unexp_stop) begin
          state_nxt = soft_resume ? psci_pkg::ST_RESUME : psci_pkg::ST_FULL;
        end
      end
    endcase
    // Static release drop always wins and demands the full sequence
    if (~stat_f) begin
      state_nxt = psci_pkg::ST_FULL;
    end
  end

  // Wishbone handshake: ack one cycle after the request, dropped next cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req & ~ack_r;
      rdat_r <= sel_ctrl ? 32'(ctrl_r) :
                sel_tmo ? 32'(tmo_s_r) :
                sel_mute ? 32'(mute_s_r) :
                sel_stat ? {16'h0000, 4'(state_r), count_r, 4'h0,
                            restart_required, unexp_r, timeout_r, release_r} :
                32'h0000_0000;
    end
  end

  // Register writes take effect at the acknowledging edge
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= psci_pkg::CTRL_RST;
      tmo_s_r <= psci_pkg::TMO_RST;
      mute_s_r <= psci_pkg::MUTE_RST;
    end else if (bus_wr) begin
      if (sel_ctrl) ctrl_r <= 11'(psci_merge(32'(ctrl_r), wb_dat_i, wb_sel_i));
      if (sel_tmo) tmo_s_r <= 9'(psci_merge(32'(tmo_s_r), wb_dat_i, wb_sel_i));
      if (sel_mute) mute_s_r <= 13'(psci_merge(32'(mute_s_r), wb_dat_i, wb_sel_i));
    end
  end

  // Pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      filt_r <= '0;
      prev_r <= '0;
    end else begin
      s1_r <= {drive_released, restart, upstroke, top_dead_center, release_start,
               release_static, presence_sensing_initiation};
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= (s2_r == s3_r) ? s3_r : filt_r;
      prev_r <= filt_r;
    end
  end

  // Millisecond prescaler; a long period, so it is a top parameter
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) pre_r <= 32'h0000_0000;
    else pre_r <= ms_tick ? 32'h0000_0000 : pre_r + 32'h0000_0001;
  end

  // Timers: low time, restart high time, sequence time, muting time
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_ms_r <= '0;
      rst_ms_r <= '0;
      seq_ms_r <= '0;
      mute_ms_r <= '0;
    end else begin
      if (presence_sensing_initiation_fall) low_ms_r <= '0;
      else if (ms_tick & ~presence_sensing_initiation_f) low_ms_r <= psci_sat_inc(low_ms_r);
      if (rise[psci_pkg::IN_RST]) rst_ms_r <= '0;
      else if (ms_tick & filt_r[psci_pkg::IN_RST]) rst_ms_r <= psci_sat_inc(rst_ms_r);
      // Restart on any entry into a timed wait, including the top rise
      if (state_nxt != state_r) seq_ms_r <= '0;
      else if (ms_tick & seq_timed) seq_ms_r <= psci_sat_inc(seq_ms_r);
      if (up_rise) mute_ms_r <= '0;
      else if (ms_tick) mute_ms_r <= psci_sat_inc(mute_ms_r);
    end
  end

  // Arming flags for where an interruption may begin and end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tdc_arm_r <= 1'b0;
      up_arm_r <= 1'b0;
      fall_ok_r <= 1'b0;
    end else begin
      if (go_run) tdc_arm_r <= 1'b0;
      else if (tdc_rise) tdc_arm_r <= 1'b1;
      if (go_run) up_arm_r <= 1'b0;
      else if (up_rise) up_arm_r <= 1'b1;
      if (presence_sensing_initiation_fall) begin
        // The start edge is judged against what was armed before it
        fall_ok_r <= in_full | tdc_arm_r | (first_up & up_arm_r);
      end else if (presence_sensing_initiation_rise) begin
        fall_ok_r <= 1'b0;
      end
    end
  end

  // Counter and restart progress; the top rise clear wins over a count
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= 4'h0;
      restart_done_r <= 1'b0;
    end else begin
      if (tdc_rise | go_run | (state_nxt == psci_pkg::ST_FULL & ~in_full)) begin
        count_r <= 4'h0;
      end else if (count_inc) begin
        count_r <= count_r + 4'h1;
      end
      if (~in_full | go_run) restart_done_r <= 1'b0;
      else if (restart_ok & mode_alt) restart_done_r <= 1'b1;
    end
  end

  // Outputs and flags; a new event beats a same-cycle clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= psci_pkg::ST_FULL;
      release_r <= 1'b0;
      timeout_r <= 1'b0;
      unexp_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      release_r <= (state_nxt == psci_pkg::ST_RUN);
      if (tmo_hit) timeout_r <= 1'b1;
      else if (go_run & in_full) timeout_r <= 1'b0;
      if ((state_r == psci_pkg::ST_RUN) & unexp_stop) unexp_r <= 1'b1;
      else if (go_run) unexp_r <= 1'b0;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign release_out = release_r;
  assign timeout_flag = timeout_r;
  assign unexpected_flag = unexp_r;
  assign restart_required = in_full & (mode_alt ? ~restart_done_r : count_done);

  // Checks
  default clocking psci_cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_STATIC_DROP: assert property (!stat_f |=> !release_r)
    else $error("release stayed high with static release low");
  AST_COUNT_MAX: assert property (count_r <= target)
    else $error("interruption count beyond configured target");
  AST_TDC_CLEAR: assert property (tdc_rise |=> count_r == 4'h0)
    else $error("counter not cleared on top rise");
  AST_TIMEOUT: assert property (tmo_hit |=> timeout_r && state_r == psci_pkg::ST_FULL)
    else $error("timeout did not flag and demand full sequence");
  AST_TMO_OFF: assert property (tmo_s_r == 9'h000 |-> !tmo_hit)
    else $error("timeout fired while disabled");
  AST_SHORT_LOW: assert property (presence_sensing_initiation_rise && !long_low |-> !count_inc)
    else $error("short interruption counted");
  AST_SHORT_RST: assert property (rst_fall && rst_ms_r < 23'(rst_min) |-> !restart_ok)
    else $error("short restart pulse accepted");
  AST_STD_ORDER: assert property (in_full && !mode_alt && go_run |-> count_done && restart_ok)
    else $error("standard sequence completed out of order");
  AST_ALT_ORDER: assert property (in_full && mode_alt && go_run |-> restart_done_r)
    else $error("alternative sequence completed without restart first");
  AST_REL2: assert property (go_run && need_rel2 |-> rel2_f)
    else $error("release rose without second release");
  AST_RELEASE_CAUSE: assert property ($rose(release_r) |-> $past(go_run))
    else $error("release rose without completed sequence");
  AST_MUTE_OFF: assert property (mute_s_r == 13'h0000 |-> !muted)
    else $error("muting active with zero limit");

  COV_FULL_STD: cover property (in_full && !mode_alt ##1 release_r);
  COV_FULL_ALT: cover property (in_full && mode_alt ##1 release_r);
  COV_CYCLE: cover property (state_r == psci_pkg::ST_CYCLE ##1 release_r);
  COV_TMO: cover property (tmo_hit);

endmodule : psci_core

// ==== test/psci_partner.sv ====
// Behavioural light curtain, press contacts and restart switch
`timescale 1ns/1ns
module psci_partner #(
  parameter int unsigned CYCLES_PER_MS = 10
) (
  // Clock
  input wire logic sys_clk,
  // Pins toward the block
  output logic presence_sensing_initiation,
  output logic release_static,
  output logic release_start,
  output logic top_dead_center,
  output logic upstroke,
  output logic restart,
  output logic drive_released
);
  // Idle levels: field clear, press at rest, no switch pressed
  initial begin
    presence_sensing_initiation = 1'b1;
    release_static = 1'b1;
    release_start = 1'b1;
    top_dead_center = 1'b0;
    // Muting and drive feedback start idle
    upstroke = 1'b0;
    restart = 1'b0;
    drive_released = 1'b0;
  end

  // Let a number of milliseconds of logic time pass
  task automatic wait_ms(input int unsigned n);
    repeat (n * CYCLES_PER_MS) @(posedge sys_clk);
  endtask : wait_ms

  // One interruption: field broken for low_ms, then clear again
  task automatic interrupt(input int unsigned low_ms);
    @(posedge sys_clk);
    presence_sensing_initiation <= 1'b0;
    wait_ms(low_ms);
    presence_sensing_initiation <= 1'b1;
    // Clear gap so that the next fall is a separate interruption
    wait_ms(20);
  endtask : interrupt

  // Restart switch held for hold_ms; the block takes it on release
  task automatic press_restart(input int unsigned hold_ms);
    @(posedge sys_clk);
    restart <= 1'b1;
    wait_ms(hold_ms);
    restart <= 1'b0;
    wait_ms(20);
  endtask : press_restart

  // Press arrives at top dead center, then leaves it again
  task automatic reach_top();
    @(posedge sys_clk);
    top_dead_center <= 1'b1;
    wait_ms(20);
    top_dead_center <= 1'b0;
  endtask : reach_top

  // Static and second release levels from the press contacts
  task automatic set_rel(input logic stat, input logic start);
    @(posedge sys_clk);
    release_static <= stat;
    release_start <= start;
  endtask : set_rel

  // Upstroke contact level from the press
  task automatic set_up(input logic v);
    @(posedge sys_clk);
    upstroke <= v;
    wait_ms(5);
  endtask : set_up

  // Drive feedback pulse: the press drive was released again
  task automatic pulse_drive();
    @(posedge sys_clk);
    drive_released <= 1'b1;
    wait_ms(5);
    drive_released <= 1'b0;
    wait_ms(5);
  endtask : pulse_drive
endmodule : psci_partner

// ==== test/psci_core_tb.sv ====
// Self-checking bench for the cycle initiation sequencer
`timescale 1ns/1ns
module psci_core_tb;
  // Short time base: one millisecond costs ten cycles
  localparam int unsigned CPM = 10;
  // Clock, reset and Wishbone master side
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  // Pins and results
  wire logic presence_sensing_initiation, release_static, release_start;
  wire logic top_dead_center, upstroke, restart, drive_released;
  logic release_out, timeout_flag, unexpected_flag, restart_required;
  // Score
  int num_errors = 0;
  int n_compared = 0;

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  psci_core #(.CYCLES_PER_MS(CPM)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .presence_sensing_initiation(presence_sensing_initiation),
    .release_static(release_static), .release_start(release_start),
    .top_dead_center(top_dead_center), .upstroke(upstroke), .restart(restart),
    .drive_released(drive_released), .release_out(release_out),
    .timeout_flag(timeout_flag), .unexpected_flag(unexpected_flag),
    .restart_required(restart_required));

  psci_partner #(.CYCLES_PER_MS(CPM)) pm (
    .sys_clk(sys_clk), .presence_sensing_initiation(presence_sensing_initiation),
    .release_static(release_static), .release_start(release_start),
    .top_dead_center(top_dead_center), .upstroke(upstroke), .restart(restart),
    .drive_released(drive_released));

  // Word comparison
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32

  // Single flag comparison
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  // Classic single cycle; hold everything until ack is seen at an edge
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                         output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    chk1(wb_ack_o, 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer

  // Register write
  task automatic wb_wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] q;
    wb_xfer(1'b1, adr, dat, q);
  endtask : wb_wr

  // Register read compared under a mask
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] msk,
                        input logic [31:0] exp);
    logic [31:0] q;
    wb_xfer(1'b0, adr, 32'h00000000, q);
    chk32(q & msk, exp);
  endtask : rd_chk

  // Release settles a few cycles after the filtered pins, so poll briefly
  task automatic wait_rel(input logic exp);
    int n;
    n = 0;
    while (release_out !== exp && n < 10) begin
      @(posedge sys_clk);
      n++;
    end
    chk1(release_out, exp);
  endtask : wait_rel

  // Reset for ten cycles, then load the control word
  task automatic do_reset(input logic [31:0] ctrl);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    wb_wr(psci_pkg::CTRL_OFS, ctrl);
  endtask : do_reset

  // Reset values, unmapped place and read-only status
  task automatic t_reset();
    do_reset(32'h00000000);
    chk1(release_out, 1'b0);
    rd_chk(psci_pkg::TMO_OFS, 32'hFFFFFFFF, 32'h0000001E);
    rd_chk(psci_pkg::MUTE_OFS, 32'hFFFFFFFF, 32'h00000000);
    wb_wr(8'h40, 32'hFFFFFFFF);
    rd_chk(8'h40, 32'hFFFFFFFF, 32'h00000000);
    wb_wr(psci_pkg::STAT_OFS, 32'hFFFFFFFF);
    rd_chk(psci_pkg::STAT_OFS, 32'h0000FFFF, 32'h00001000);
    $display("test reset_values done");
  endtask : t_reset

  // Standard order with refused early restart, short pulses ignored
  task automatic t_std();
    pm.press_restart(150);
    chk1(release_out, 1'b0);
    pm.interrupt(50);
    rd_chk(psci_pkg::STAT_OFS, 32'h00000F00, 32'h00000000);
    pm.interrupt(150);
    rd_chk(psci_pkg::STAT_OFS, 32'h00000F08, 32'h00000108);
    pm.press_restart(50);
    chk1(release_out, 1'b0);
    pm.press_restart(150);
    wait_rel(1'b1);
    $display("test standard done");
  endtask : t_std

  // Static release drop, then a full sequence is demanded again
  task automatic t_static();
    pm.set_rel(1'b0, 1'b1);
    wait_rel(1'b0);
    pm.set_rel(1'b1, 1'b1);
    pm.press_restart(150);
    chk1(release_out, 1'b0);
    pm.interrupt(150);
    pm.press_restart(150);
    wait_rel(1'b1);
    $display("test static_drop done");
  endtask : t_static

  // Two interruptions per cycle; the top edge clears the count
  task automatic t_cycle();
    do_reset(32'h00000001);
    pm.interrupt(150);
    pm.interrupt(150);
    pm.press_restart(150);
    wait_rel(1'b1);
    pm.reach_top();
    rd_chk(psci_pkg::STAT_OFS, 32'h00000F00, 32'h00000000);
    pm.interrupt(150);
    chk1(release_out, 1'b0);
    pm.interrupt(150);
    wait_rel(1'b1);
    $display("test cycle_start done");
  endtask : t_cycle

  // One second limit runs out; zero disables the watch
  task automatic t_timeout();
    wb_wr(psci_pkg::TMO_OFS, 32'h00000001);
    pm.reach_top();
    pm.wait_ms(850);
    chk1(timeout_flag, 1'b0);
    pm.wait_ms(250);
    chk1(timeout_flag, 1'b1);
    pm.interrupt(150);
    pm.interrupt(150);
    chk1(release_out, 1'b0);
    pm.press_restart(150);
    wait_rel(1'b1);
    chk1(timeout_flag, 1'b0);
    wb_wr(psci_pkg::TMO_OFS, 32'h00000000);
    pm.reach_top();
    pm.wait_ms(1100);
    chk1(timeout_flag, 1'b0);
    $display("test timeout done");
  endtask : t_timeout

  // Alternative order with the largest count of eight
  task automatic t_alt();
    do_reset(32'h0000000F);
    rd_chk(psci_pkg::STAT_OFS, 32'h00000008, 32'h00000008);
    pm.press_restart(150);
    for (int i = 0; i < 7; i++) begin
      pm.interrupt(150);
    end
    chk1(release_out, 1'b0);
    pm.interrupt(150);
    wait_rel(1'b1);
    $display("test alternative done");
  endtask : t_alt

  // Each second release setting with that input held low
  task automatic t_rel2();
    logic [1:0] code [3] = '{psci_pkg::REL2_EVERY, psci_pkg::REL2_FIRST, psci_pkg::REL2_OFF};
    logic expv [3] = '{1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 3; i++) begin
      do_reset(32'(code[i]) << psci_pkg::REL2_LSB);
      pm.set_rel(1'b1, 1'b0);
      pm.interrupt(150);
      pm.press_restart(150);
      chk1(release_out, expv[i]);
    end
    pm.set_rel(1'b1, 1'b1);
    $display("test second_release done");
  endtask : t_rel2

  // Upstroke muting, resume without interlock, drive feedback rise
  task automatic t_mute_drive();
    wb_wr(psci_pkg::MUTE_OFS, 32'h00000001);
    pm.set_up(1'b1);
    pm.interrupt(150);
    chk1(release_out, 1'b1);
    pm.set_up(1'b0);
    wb_wr(psci_pkg::MUTE_OFS, 32'h00000000);
    wb_wr(psci_pkg::CTRL_OFS, 32'h00000020);
    pm.interrupt(150);
    wait_rel(1'b1);
    pm.reach_top();
    pm.pulse_drive();
    pm.interrupt(150);
    chk1(release_out, 1'b0);
    pm.press_restart(150);
    wait_rel(1'b1);
    $display("test muting_drive done");
  endtask : t_mute_drive

  // Verdict, in one place only
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    t_reset();
    t_std();
    t_static();
    t_cycle();
    t_timeout();
    t_alt();
    t_rel2();
    t_mute_drive();
    end_of_test();
  end

  // Watchdog well beyond the roughly 81k cycles the tests need
  initial begin
    repeat (200000) @(posedge sys_clk);
    num_errors++;
    end_of_test();
  end
endmodule : psci_core_tb
